// ==== hbc_core.sv ====
// Control logic of a two-input full-bridge motor driver: decode, standby,
// chopping with mixed decay, synchronous rectification and protection.
// Assumes pins and analog comparators arrive asynchronously; gate drive is outside.
// Function
// - both inputs low: both outputs float
// - A low, B high: reverse drive
// - A high, B low: forward drive
// - both inputs high: both outputs low
// - inputs low over 1ms: enter standby
// - standby switches off pump
// - chop trip ends drive, starts mixed decay
// - decay lasts fixed 24us off-time
// - decay is fast first, then slow
// - trip when sense equals reference over ten
// - recirculation turns transistors on
// - zero current ends synchronous rectification
// - persistent current limit disables all transistors
// - retry after period, repeat if fault
// - undervoltage disables all, resets logic
// - resume when supply recovers
// - overtemperature disables until cool
// - limit persistence time is 1.5us
// - retry period is 3ms
module hbc_core #(
   parameter int unsigned STANDBY_CYC = hbc_pkg::STANDBY_CYC,
   parameter int unsigned RETRY_CYC = hbc_pkg::RETRY_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic bridge_input_a,
   input wire logic bridge_input_b,
   input wire hbc_pkg::hbc_sense_t sense_raw,
   output hbc_pkg::hbc_bridge_t gates,
   output logic bridge_output_a,
   output logic bridge_output_a_oe,
   output logic bridge_output_b,
   output logic bridge_output_b_oe,
   output logic standby,
   output logic charge_pump_en,
   output logic fault
);
   localparam int W = 8;
   localparam logic [19:0] STB_C = 20'(STANDBY_CYC);
   localparam logic [19:0] RTY_C = 20'(RETRY_CYC);
   localparam logic [19:0] OFF_C = 20'(hbc_pkg::OFF_CYC);
   localparam logic [19:0] FAST_C = 20'(hbc_pkg::FAST_CYC);
   localparam logic [19:0] BLK_C = 20'(hbc_pkg::BLANK_CYC);
   localparam logic [19:0] REG_C = 20'(hbc_pkg::OCP_REG_CYC);

   typedef struct packed {
      hbc_pkg::hbc_state_t fsm;
      logic [19:0] stb_cnt;
      logic [19:0] tmr;
      logic [19:0] blk_cnt;
      logic [19:0] lim_cnt;
      logic standby;
      logic sr_on;
      hbc_pkg::hbc_bridge_t gates;
      logic [1:0] pins;
   } hbc_core_st_t;

   hbc_core_st_t st;
   hbc_core_st_t next_st;
   logic [W-1:0] sy;
   logic in_a;
   logic in_b;
   logic lim;
   logic uv;
   logic hot;
   logic zc;
   logic trip;

   // Comparator already scales sense against reference over the gain of ten
   hbc_sync #(.W(W)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .async_in({bridge_input_a, bridge_input_b, sense_raw}),
      .sync_out(sy)
   );

   assign in_a = sy[7];
   assign in_b = sy[6];
   assign lim = sy[5] | sy[4];
   assign uv = sy[3];
   assign hot = sy[2];
   assign zc = sy[1];
   assign trip = sy[0];

   always_comb begin
      next_st = st;
      next_st.pins = {in_a, in_b};
      // Standby timer restarts whenever an input is high
      if (in_a | in_b) begin
         next_st.stb_cnt = '0;
         next_st.standby = 1'b0;
      end else if (st.stb_cnt >= STB_C) begin
         next_st.standby = 1'b1;
      end else begin
         next_st.stb_cnt = st.stb_cnt + 20'h00001;
      end
      // Blanking restarts on each change of the drive pattern
      if (st.pins != {in_a, in_b}) begin
         next_st.blk_cnt = '0;
      end else if (st.blk_cnt < BLK_C) begin
         next_st.blk_cnt = st.blk_cnt + 20'h00001;
      end
      // Current limit persistence
      if (lim && st.fsm != hbc_pkg::HBC_ST_OCP) begin
         next_st.lim_cnt = st.lim_cnt + 20'h00001;
      end else begin
         next_st.lim_cnt = '0;
      end
      case (st.fsm)
         hbc_pkg::HBC_ST_RUN: begin
            if (st.lim_cnt >= REG_C) begin
               next_st.fsm = hbc_pkg::HBC_ST_OCP;
               next_st.tmr = '0;
            end else if (trip && st.blk_cnt >= BLK_C && (in_a ^ in_b)) begin
               next_st.fsm = hbc_pkg::HBC_ST_FAST;
               next_st.tmr = '0;
               next_st.sr_on = 1'b1;
            end
         end
         hbc_pkg::HBC_ST_FAST: begin
            next_st.tmr = st.tmr + 20'h00001;
            if (zc) begin
               next_st.sr_on = 1'b0;
            end
            if (st.tmr + 20'h00001 >= FAST_C) begin
               next_st.fsm = hbc_pkg::HBC_ST_SLOW;
            end
            // Coast or brake from the host ends decay, so the truth table holds
            if (!(in_a ^ in_b)) begin
               next_st.fsm = hbc_pkg::HBC_ST_RUN;
               next_st.blk_cnt = '0;
               next_st.sr_on = 1'b0;
            end
         end
         hbc_pkg::HBC_ST_SLOW: begin
            next_st.tmr = st.tmr + 20'h00001;
            if (zc) begin
               next_st.sr_on = 1'b0;
            end
            if (st.tmr + 20'h00001 >= OFF_C) begin
               next_st.fsm = hbc_pkg::HBC_ST_RUN;
               next_st.blk_cnt = '0;
               next_st.sr_on = 1'b0;
            end
            // Slow decay would otherwise hold both low sides on with both inputs low
            if (!(in_a ^ in_b)) begin
               next_st.fsm = hbc_pkg::HBC_ST_RUN;
               next_st.blk_cnt = '0;
               next_st.sr_on = 1'b0;
            end
         end
         hbc_pkg::HBC_ST_OCP: begin
            next_st.tmr = st.tmr + 20'h00001;
            if (st.tmr + 20'h00001 >= RTY_C) begin
               next_st.fsm = hbc_pkg::HBC_ST_RUN;
               next_st.blk_cnt = '0;
               next_st.tmr = '0;
            end
         end
         hbc_pkg::HBC_ST_SHUT: begin
            if (!hot) begin
               next_st.fsm = hbc_pkg::HBC_ST_RUN;
               next_st.blk_cnt = '0;
            end
         end
         default: begin
            next_st.fsm = hbc_pkg::HBC_ST_RUN;
         end
      endcase
      if (hot) begin
         next_st.fsm = hbc_pkg::HBC_ST_SHUT;
         next_st.sr_on = 1'b0;
      end
      // Gate pattern from the truth table, overridden by decay and faults
      next_st.gates = '0;
      case ({in_a, in_b})
         2'h1: begin
            next_st.gates.a.ls_on = 1'b1;
            next_st.gates.b.hs_on = 1'b1;
         end
         2'h2: begin
            next_st.gates.a.hs_on = 1'b1;
            next_st.gates.b.ls_on = 1'b1;
         end
         2'h3: begin
            next_st.gates.a.ls_on = 1'b1;
            next_st.gates.b.ls_on = 1'b1;
         end
         default: begin
            next_st.gates = '0;
         end
      endcase
      if (next_st.fsm == hbc_pkg::HBC_ST_FAST) begin
         // Reverse the bridge so current returns to the supply
         next_st.gates.a.hs_on = next_st.sr_on & in_b;
         next_st.gates.a.ls_on = next_st.sr_on & in_a;
         next_st.gates.b.hs_on = next_st.sr_on & in_a;
         next_st.gates.b.ls_on = next_st.sr_on & in_b;
      end else if (next_st.fsm == hbc_pkg::HBC_ST_SLOW) begin
         // Both low sides short the winding
         next_st.gates.a.hs_on = 1'b0;
         next_st.gates.b.hs_on = 1'b0;
         next_st.gates.a.ls_on = next_st.sr_on;
         next_st.gates.b.ls_on = next_st.sr_on;
      end else if (next_st.fsm == hbc_pkg::HBC_ST_OCP
                   || next_st.fsm == hbc_pkg::HBC_ST_SHUT) begin
         next_st.gates = '0;
      end
      if (next_st.standby) begin
         next_st.gates = '0;
      end
   end

   // Undervoltage behaves as a logic reset, so recovery is a clean restart
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '0;
         st.fsm <= hbc_pkg::HBC_ST_RUN;
         st.pins <= hbc_pkg::RESET_PINS;
      end else if (clk_en) begin
         if (uv) begin
            st <= '0;
            st.fsm <= hbc_pkg::HBC_ST_RUN;
            st.pins <= hbc_pkg::RESET_PINS;
         end else begin
            st <= next_st;
         end
      end
   end

   assign gates = st.gates;
   assign bridge_output_a = st.gates.a.hs_on;
   assign bridge_output_a_oe = st.gates.a.hs_on | st.gates.a.ls_on;
   assign bridge_output_b = st.gates.b.hs_on;
   assign bridge_output_b_oe = st.gates.b.hs_on | st.gates.b.ls_on;
   // Pump stays off in standby; the host must allow settling after wake
   assign standby = st.standby;
   assign charge_pump_en = ~st.standby & ~uv;
   assign fault = (st.fsm == hbc_pkg::HBC_ST_OCP) | (st.fsm == hbc_pkg::HBC_ST_SHUT) | uv;

   property p_coast;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && !in_a && !in_b && !uv) |=> (!bridge_output_a_oe && !bridge_output_b_oe);
   endproperty
   a_coast: assert property (p_coast) else $error("coast not floating");

   property p_fwd;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && in_a && !in_b && !uv && !hot && next_st.fsm == hbc_pkg::HBC_ST_RUN)
         |=> (gates.a.hs_on && gates.b.ls_on);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward drive wrong");

   property p_brake;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && in_a && in_b && !uv && next_st.fsm == hbc_pkg::HBC_ST_RUN)
         |=> (gates.a.ls_on && gates.b.ls_on && !gates.a.hs_on && !gates.b.hs_on);
   endproperty
   a_brake: assert property (p_brake) else $error("brake wrong");

   property p_standby_gates;
      @(posedge sys_clk) disable iff (rst)
         standby |-> (gates == '0 && !charge_pump_en);
   endproperty
   a_standby_gates: assert property (p_standby_gates) else $error("drive in standby");

   property p_wake;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && (in_a || in_b)) |=> !standby;
   endproperty
   a_wake: assert property (p_wake) else $error("standby not left");

   property p_ocp_off;
      @(posedge sys_clk) disable iff (rst)
         (st.fsm == hbc_pkg::HBC_ST_OCP) |-> gates == '0;
   endproperty
   a_ocp_off: assert property (p_ocp_off) else $error("gates on during retry");

   property p_decay_order;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && st.fsm == hbc_pkg::HBC_ST_RUN && next_st.fsm == hbc_pkg::HBC_ST_FAST && !hot && !uv)
         |=> st.fsm == hbc_pkg::HBC_ST_FAST;
   endproperty
   a_decay_order: assert property (p_decay_order) else $error("decay not fast first");

   property p_uv_reset;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && uv) |=> (gates == '0 && st.fsm == hbc_pkg::HBC_ST_RUN && !st.standby);
   endproperty
   a_uv_reset: assert property (p_uv_reset) else $error("undervoltage not reset");

   property p_hot;
      @(posedge sys_clk) disable iff (rst)
         (clk_en && hot && !uv) |=> (st.fsm == hbc_pkg::HBC_ST_SHUT && gates == '0);
   endproperty
   a_hot: assert property (p_hot) else $error("thermal not off");

   c_standby: cover property (@(posedge sys_clk) disable iff (rst) $rose(standby));
   c_decay: cover property (@(posedge sys_clk) disable iff (rst) st.fsm == hbc_pkg::HBC_ST_SLOW);
   c_retry: cover property (@(posedge sys_clk) disable iff (rst) $fell(st.fsm == hbc_pkg::HBC_ST_OCP));
endmodule : hbc_core

// ==== hbc_core_tb.sv ====
// Self-checking bench for the bridge control core, with a host model on the pins.
// Assumes shortened standby and retry counts; all other counts are the package's.
module hbc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SB_CYC = 100;
   localparam int RT_CYC = 200;
   localparam logic [3:0] G_FWD = 4'h9;
   localparam logic [3:0] G_REV = 4'h6;
   localparam logic [3:0] G_BRK = 4'h5;
   localparam logic [3:0] G_OFF = 4'h0;
   // Fault, standby, pump enable
   localparam logic [2:0] RUN = 3'h1;
   localparam logic [2:0] SBY = 3'h2;
   localparam logic [2:0] FLT = 3'h5;
   localparam logic [2:0] UVF = 3'h4;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic clk_en = 1'h1;
   logic bridge_input_a;
   logic bridge_input_b;
   hbc_pkg::hbc_sense_t sense_raw = '0;
   hbc_pkg::hbc_bridge_t gates;
   logic bridge_output_a;
   logic bridge_output_a_oe;
   logic bridge_output_b;
   logic bridge_output_b_oe;
   logic standby;
   logic charge_pump_en;
   logic fault;
   logic [10:0] seen;
   int miscompares = 0;
   int samples_checked = 0;

   hbc_host host_u (.sys_clk(sys_clk), .bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b));

   hbc_core #(.STANDBY_CYC(SB_CYC), .RETRY_CYC(RT_CYC)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .bridge_input_a(bridge_input_a),
      .bridge_input_b(bridge_input_b), .sense_raw(sense_raw), .gates(gates),
      .bridge_output_a(bridge_output_a), .bridge_output_a_oe(bridge_output_a_oe),
      .bridge_output_b(bridge_output_b), .bridge_output_b_oe(bridge_output_b_oe),
      .standby(standby), .charge_pump_en(charge_pump_en), .fault(fault));

   assign seen = {fault, standby, charge_pump_en, bridge_output_a_oe, bridge_output_b_oe,
                  bridge_output_a, bridge_output_b, gates};

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   // Pin levels and enables follow from the gate pattern alone
   function automatic logic [10:0] exp_of(input logic [2:0] fsp, input logic [3:0] g);
      return {fsp, g[3] | g[2], g[1] | g[0], g[3], g[1], g};
   endfunction : exp_of

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_for(input string what, input logic [10:0] exp, input int bound);
      int n = 0;
      while (seen !== exp && n < bound) begin
         @(negedge sys_clk);
         n++;
      end
      check(what, exp);
      if (seen !== exp) final_report();
   endtask : wait_for

   task automatic hold(input int cyc);
      repeat (cyc) @(negedge sys_clk);
   endtask : hold

   task automatic t_truth();
      host_u.drive(1'h0, 1'h1);
      wait_for("reverse", exp_of(RUN, G_REV), 6);
      host_u.drive(1'h1, 1'h1);
      wait_for("brake", exp_of(RUN, G_BRK), 6);
      host_u.drive(1'h1, 1'h0);
      wait_for("forward", exp_of(RUN, G_FWD), 6);
      host_u.drive(1'h0, 1'h0);
      wait_for("coast", exp_of(RUN, G_OFF), 6);
      $display("test truth table done");
   endtask : t_truth

   task automatic t_standby();
      hold(SB_CYC / 2);
      host_u.drive(1'h1, 1'h0);
      hold(3);
      host_u.drive(1'h0, 1'h0);
      hold(SB_CYC - 10);
      check("timer restart", exp_of(RUN, G_OFF));
      wait_for("standby", exp_of(SBY, G_OFF), 20);
      host_u.wake(1'h1, 1'h0);
      check("wake", exp_of(RUN, G_FWD));
      $display("test standby done");
   endtask : t_standby

   task automatic t_chop(input logic zc);
      hold(60);
      sense_raw.chop_trip = 1'h1;
      wait_for("fast", exp_of(RUN, G_REV), 6);
      sense_raw.chop_trip = 1'h0;
      if (zc) begin
         sense_raw.zero_current = 1'h1;
         wait_for("zero", exp_of(RUN, G_OFF), 6);
         sense_raw.zero_current = 1'h0;
         hold(300);
         check("zero hold", exp_of(RUN, G_OFF));
      end else begin
         hold(150);
         check("fast hold", exp_of(RUN, G_REV));
         wait_for("slow", exp_of(RUN, G_BRK), 60);
         hold(300);
         check("slow hold", exp_of(RUN, G_BRK));
      end
      wait_for("resume", exp_of(RUN, G_FWD), 400);
      $display("test chopping done");
   endtask : t_chop

   task automatic t_ocp();
      sense_raw.ocp_limit_a = 1'h1;
      hold(20);
      sense_raw.ocp_limit_a = 1'h0;
      hold(30);
      check("short limit", exp_of(RUN, G_FWD));
      sense_raw.ocp_limit_b = 1'h1;
      wait_for("ocp off", exp_of(FLT, G_OFF), 45);
      hold(RT_CYC - 20);
      check("retry hold", exp_of(FLT, G_OFF));
      wait_for("retry on", exp_of(RUN, G_FWD), 40);
      wait_for("ocp again", exp_of(FLT, G_OFF), 45);
      sense_raw.ocp_limit_b = 1'h0;
      wait_for("recovered", exp_of(RUN, G_FWD), RT_CYC + 40);
      hold(100);
      check("stays on", exp_of(RUN, G_FWD));
      $display("test overcurrent done");
   endtask : t_ocp

   task automatic t_prot();
      sense_raw.ocp_limit_a = 1'h1;
      wait_for("ocp off", exp_of(FLT, G_OFF), 45);
      sense_raw.undervoltage_lockout = 1'h1;
      wait_for("uv off", exp_of(UVF, G_OFF), 6);
      sense_raw.ocp_limit_a = 1'h0;
      sense_raw.undervoltage_lockout = 1'h0;
      // Retry state was cleared, so drive returns well before the retry period
      wait_for("uv resume", exp_of(RUN, G_FWD), 8);
      sense_raw.thermal_cutoff = 1'h1;
      wait_for("hot off", exp_of(FLT, G_OFF), 6);
      hold(100);
      check("hot hold", exp_of(FLT, G_OFF));
      sense_raw.thermal_cutoff = 1'h0;
      wait_for("cool resume", exp_of(RUN, G_FWD), 8);
      $display("test protection done");
   endtask : t_prot

   initial begin
      hold(2);
      check("reset", exp_of(RUN, G_OFF));
      rst = 1'h0;
      t_truth();
      t_standby();
      t_chop(1'h0);
      t_chop(1'h1);
      t_ocp();
      t_prot();
      final_report();
   end

   initial begin
      repeat (100000) @(posedge sys_clk);
      miscompares++;
      final_report();
   end
endmodule : hbc_core_tb

// ==== hbc_host.sv ====
// Host model: drives the two bridge inputs of the core at the falling edge.
// Assumes the core's 25 MHz sys_clk; the pump settling time is counted in it.
module hbc_host #(
   parameter int SETTLE_CYC = 5000
) (
   input wire logic sys_clk,
   output logic bridge_input_a,
   output logic bridge_input_b
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      bridge_input_a = 1'h0;
      bridge_input_b = 1'h0;
   end

   task automatic drive(input logic a, input logic b);
      @(negedge sys_clk);
      bridge_input_a = a;
      bridge_input_b = b;
   endtask : drive

   // Commands right after standby may be lost, so the host waits out the pump
   task automatic wake(input logic a, input logic b);
      drive(a, b);
      repeat (SETTLE_CYC) @(negedge sys_clk);
   endtask : wake
endmodule : hbc_host

// ==== hbc_pkg.sv ====
// Package for the H-bridge control logic: timing constants, states and carriers.
// Assumes a 25 MHz sys_clk; all counts are derived from times in their own unit.
package hbc_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   // Times as printed, in nanoseconds
   localparam int unsigned STANDBY_NS = 1000000;
   localparam int unsigned OFF_NS = 24000;
   localparam int unsigned BLANK_NS = 2000;
   localparam int unsigned FAST_NS = 8000;
   localparam int unsigned OCP_REG_NS = 1500;
   localparam int unsigned RETRY_NS = 3000000;
   localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
   // Cycle counts: least times round up
   localparam int unsigned STANDBY_CYC = (STANDBY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OFF_CYC = (OFF_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned FAST_CYC = (FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OCP_REG_CYC = (OCP_REG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RETRY_CYC = (RETRY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CHOP_GAIN = 10;
   localparam int unsigned CNT_W = 20;
   localparam logic [1:0] RESET_PINS = 2'h0;

   typedef enum logic [4:0] {
      HBC_ST_RUN = 5'h01,
      HBC_ST_FAST = 5'h02,
      HBC_ST_SLOW = 5'h04,
      HBC_ST_OCP = 5'h08,
      HBC_ST_SHUT = 5'h10
   } hbc_state_t;

   // One half-bridge: gate commands for high and low side
   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } hbc_half_t;

   typedef struct packed {
      hbc_half_t a;
      hbc_half_t b;
   } hbc_bridge_t;

   typedef struct packed {
      logic ocp_limit_a;
      logic ocp_limit_b;
      logic undervoltage_lockout;
      logic thermal_cutoff;
      logic zero_current;
      logic chop_trip;
   } hbc_sense_t;
endpackage : hbc_pkg

// ==== hbc_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes a single clock; the first stage feeds only the second.
module hbc_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hbc_sync_st_t;
   hbc_sync_st_t st;
   hbc_sync_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;
endmodule : hbc_sync
